// ==== design/arm_router_pkg.sv ====
package arm_router_pkg;

  // ***************************************************************
  // System shape
  // ***************************************************************
  localparam int MAIN_SLOTS   = 5;
  localparam int EXP_SLOTS    = 5;
  localparam int TOTAL_SLOTS  = MAIN_SLOTS + EXP_SLOTS;
  localparam int MAX_CHAIN    = 5;
  localparam int SEL_W        = 4;

  // ***************************************************************
  // Arming source codes
  // ***************************************************************
  // 0..4 main modules A..E, 5..9 expansion modules F..J, 10 rear input
  localparam logic [SEL_W-1:0] SRC_FIRST_EXP = 4'h5;
  localparam logic [SEL_W-1:0] SRC_REAR_IN   = 4'hA;
  localparam logic [SEL_W-1:0] SRC_NONE      = 4'hF;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [SEL_W-1:0] RST_SEL       = SRC_NONE;

  // ***************************************************************
  // Link states
  // ***************************************************************
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_PROBE,
    LINK_UP,
    LINK_ABSENT
  } link_state_t;

  localparam int PROBE_CYCLES = 8;

  // Decode one source code into a one-hot over the source vector
  function automatic logic [TOTAL_SLOTS:0] srcOneHot(input logic [SEL_W-1:0] s);
    logic [TOTAL_SLOTS:0] v;
    v = '0;
    if (s <= SRC_REAR_IN) begin
      v[s] = 1'b1;
    end
    return v;
  endfunction

endpackage

// ==== design/arm_select_mux.sv ====
`timescale 1ns/100ps
`default_nettype none

module arm_select_mux #(
  parameter int N = 11
) (
  // Source vector
  input  wire logic [N-1:0]                           srcVec,
  // Selection
  input  wire logic [arm_router_pkg::SEL_W-1:0]       sel,
  // Result
  output logic                                        armOut
);

  always_comb begin
    armOut = |(srcVec & arm_router_pkg::srcOneHot(sel));
  end

endmodule // arm_select_mux

`default_nettype wire

// ==== design/chain_depth_check.sv ====
`timescale 1ns/100ps
`default_nettype none

module chain_depth_check (
  // Selections, four bits per module
  input  wire logic [arm_router_pkg::TOTAL_SLOTS*arm_router_pkg::SEL_W-1:0] selFlat,
  // Per-module verdict: chain too deep or cyclic
  output logic [arm_router_pkg::TOTAL_SLOTS-1:0]                            tooDeep
);

  localparam int T = arm_router_pkg::TOTAL_SLOTS;
  localparam int W = arm_router_pkg::SEL_W;

  // Walk each module's chain up to the limit; still on a module afterwards
  // means depth beyond five (cycles also land here)
  always_comb begin
    logic [W-1:0] cur;
    cur = '0;
    tooDeep = '0;
    for (int m = 0; m < T; m++) begin
      cur = W'(m);
      for (int d = 0; d < arm_router_pkg::MAX_CHAIN; d++) begin
        if (cur < W'(T)) begin
          cur = selFlat[cur*W +: W];
        end
      end
      tooDeep[m] = (cur < W'(T));
    end
  end

endmodule // chain_depth_check

`default_nettype wire

// ==== design/intermodule_arming_router.sv ====
`timescale 1ns/100ps
`default_nettype none

module intermodule_arming_router (
  // Clock and reset
  input  wire logic                                     core_clk,
  input  wire logic                                     sys_rst,
  // Configuration write port
  input  wire logic                                     cfgWrite,
  input  wire logic [3:0]                               cfgSlot,
  input  wire logic [arm_router_pkg::SEL_W-1:0]         cfgSource,
  output logic                                          cfgReject,
  // Rear output source: an expansion slot index 0..4, or main-frame drive
  input  wire logic                                     trigOutFromExp,
  input  wire logic [2:0]                               trigOutExpSlot,
  // Module arm outputs and trigger outputs
  input  wire logic [arm_router_pkg::TOTAL_SLOTS-1:0]   moduleTrig,
  output logic [arm_router_pkg::TOTAL_SLOTS-1:0]        moduleArm,
  // Rear panel
  input  wire logic                                     rearArmIn,
  input  wire logic                                     mainTrigOut,
  output logic                                          rearTrigOut,
  // Interframe link control
  input  wire logic                                     expPresent,
  output logic                                          linkCtrlValid,
  output logic [3:0]                                    linkCtrlSlot,
  output logic [arm_router_pkg::SEL_W-1:0]              linkCtrlSource,
  output logic                                          linkUp,
  // Status
  output logic [arm_router_pkg::TOTAL_SLOTS-1:0]        chainTooDeep,
  output logic                                          sharedPathConflict
);

  localparam int T = arm_router_pkg::TOTAL_SLOTS;
  localparam int M = arm_router_pkg::MAIN_SLOTS;
  localparam int W = arm_router_pkg::SEL_W;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [T-1:0][W-1:0]          sel;
    logic [W-1:0]                 mainExtSel;
    logic [W-1:0]                 expExtSel;
    arm_router_pkg::link_state_t  link;
    logic [3:0]                   probeCnt;
    logic                         ctrlValid;
    logic [3:0]                   ctrlSlot;
    logic [W-1:0]                 ctrlSource;
    logic                         reject;
    logic                         trigOut;
    logic [T-1:0]                 arm;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  logic [T:0]     srcVec;
  logic [T-1:0]   armRaw;
  logic [T-1:0]   deep;
  logic [T*W-1:0] selFlat;
  logic           crossMain;
  logic           crossExp;

  // ***************************************************************
  // Datapath
  // ***************************************************************
  // Source vector: A..E, F..J, rear input
  assign srcVec = {rearArmIn, moduleTrig};

  genvar g;
  generate
    for (g = 0; g < T; g++) begin : gArm
      arm_select_mux #(
        .N      (T + 1)
      ) uMux (
        .srcVec (srcVec),
        .sel    (stateReg.sel[g]),
        .armOut (armRaw[g])
      );
      assign selFlat[g*W +: W] = stateReg.sel[g];
    end
  endgenerate

  chain_depth_check uDepth (
    .selFlat (selFlat),
    .tooDeep (deep)
  );

  // Is this source across the frame boundary for a module in the given frame
  function automatic logic crosses(input logic isMain, input logic [W-1:0] s);
    if (isMain) begin
      return (s >= arm_router_pkg::SRC_FIRST_EXP) && (s <= arm_router_pkg::SRC_REAR_IN);
    end
    return (s < arm_router_pkg::SRC_FIRST_EXP) || (s == arm_router_pkg::SRC_REAR_IN);
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic isMain;
    logic legal;
    stateNext = stateReg;
    isMain = 1'b0;
    legal = 1'b0;
    stateNext.ctrlValid = 1'b0;
    stateNext.reject = 1'b0;

    // Power-up link probe
    unique case (stateReg.link)
      arm_router_pkg::LINK_IDLE: begin
        stateNext.link = arm_router_pkg::LINK_PROBE;
        stateNext.probeCnt = 4'h0;
      end
      arm_router_pkg::LINK_PROBE: begin
        if (expPresent) begin
          stateNext.link = arm_router_pkg::LINK_UP;
        end else if (stateReg.probeCnt == 4'(arm_router_pkg::PROBE_CYCLES - 1)) begin
          stateNext.link = arm_router_pkg::LINK_ABSENT;
        end else begin
          stateNext.probeCnt = stateReg.probeCnt + 4'h1;
        end
      end
      arm_router_pkg::LINK_UP: begin
      end
      arm_router_pkg::LINK_ABSENT: begin
      end
    endcase

    if (cfgWrite && (cfgSlot < 4'(T))) begin
      isMain = cfgSlot < 4'(M);
      legal = 1'b1;
      // Self-arming is refused; other modules pass here, but cross-frame ones still face the link and one-per-frame checks below
      if (cfgSource == W'(cfgSlot)) begin
        legal = 1'b0;
      end
      if ((cfgSource > arm_router_pkg::SRC_REAR_IN) && (cfgSource != arm_router_pkg::SRC_NONE)) begin
        legal = 1'b0;
      end
      // Cross-frame sources need the other frame to be there
      if (crosses(isMain, cfgSource) && (cfgSource != arm_router_pkg::SRC_REAR_IN || !isMain)) begin
        if (stateReg.link != arm_router_pkg::LINK_UP) begin
          legal = 1'b0;
        end
        // One cross-frame signal per frame
        if (isMain && stateReg.mainExtSel != arm_router_pkg::SRC_NONE
            && stateReg.mainExtSel != cfgSource) begin
          legal = 1'b0;
        end
        if (!isMain && stateReg.expExtSel != arm_router_pkg::SRC_NONE
            && stateReg.expExtSel != cfgSource) begin
          legal = 1'b0;
        end
      end
      if (legal) begin
        stateNext.sel[cfgSlot] = cfgSource;
        // Forward the selection to the expansion interface logic
        stateNext.ctrlValid = 1'b1;
        stateNext.ctrlSlot = cfgSlot;
        stateNext.ctrlSource = cfgSource;
      end else begin
        stateNext.reject = 1'b1;
      end
    end else if (cfgWrite) begin
      stateNext.reject = 1'b1;
    end

    // Recompute the single external source of each frame from the held map
    stateNext.mainExtSel = arm_router_pkg::SRC_NONE;
    stateNext.expExtSel = arm_router_pkg::SRC_NONE;
    for (int i = 0; i < T; i++) begin
      if (crosses(i < M, stateNext.sel[i]) && !(i < M && stateNext.sel[i] == arm_router_pkg::SRC_REAR_IN)) begin
        if (i < M) begin
          stateNext.mainExtSel = stateNext.sel[i];
        end else begin
          stateNext.expExtSel = stateNext.sel[i];
        end
      end
    end

    // Arms are gated off on too-deep chains; cross-frame arms need the link
    for (int i = 0; i < T; i++) begin
      stateNext.arm[i] = armRaw[i] && !deep[i];
      if (crosses(i < M, stateReg.sel[i]) && stateReg.link != arm_router_pkg::LINK_UP
          && !(i < M && stateReg.sel[i] == arm_router_pkg::SRC_REAR_IN)) begin
        stateNext.arm[i] = 1'b0;
      end
    end

    // Rear trigger output lives only on the main frame
    if (trigOutFromExp && stateReg.link == arm_router_pkg::LINK_UP
        && trigOutExpSlot < 3'(arm_router_pkg::EXP_SLOTS)) begin
      stateNext.trigOut = moduleTrig[M + int'(trigOutExpSlot)];
    end else begin
      stateNext.trigOut = mainTrigOut;
    end

    if (sys_rst) begin
      for (int i = 0; i < T; i++) begin
        stateNext.sel[i] = arm_router_pkg::RST_SEL;
      end
      stateNext.mainExtSel = arm_router_pkg::SRC_NONE;
      stateNext.expExtSel = arm_router_pkg::SRC_NONE;
      stateNext.link = arm_router_pkg::LINK_IDLE;
      stateNext.probeCnt = 4'h0;
      stateNext.ctrlValid = 1'b0;
      stateNext.ctrlSlot = 4'h0;
      stateNext.ctrlSource = arm_router_pkg::SRC_NONE;
      stateNext.reject = 1'b0;
      stateNext.trigOut = 1'b0;
      stateNext.arm = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    stateReg <= stateNext;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Main modules using the rear input while the main frame also takes an
  // expansion source: both ride one path, so software should re-chain
  always_comb begin
    logic rearUsed;
    rearUsed = 1'b0;
    for (int i = 0; i < M; i++) begin
      rearUsed = rearUsed | (stateReg.sel[i] == arm_router_pkg::SRC_REAR_IN);
    end
    crossMain = stateReg.mainExtSel != arm_router_pkg::SRC_NONE;
    crossExp = stateReg.expExtSel != arm_router_pkg::SRC_NONE;
    sharedPathConflict = rearUsed && crossMain;
  end

  assign moduleArm      = stateReg.arm;
  assign rearTrigOut    = stateReg.trigOut;
  assign cfgReject      = stateReg.reject;
  assign linkCtrlValid  = stateReg.ctrlValid;
  assign linkCtrlSlot   = stateReg.ctrlSlot;
  assign linkCtrlSource = stateReg.ctrlSource;
  assign linkUp         = stateReg.link == arm_router_pkg::LINK_UP;
  assign chainTooDeep   = deep;

endmodule // intermodule_arming_router

`default_nettype wire

// ==== tb/arm_router_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module arm_router_monitor (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Watched ports
  input wire logic       cfgWrite,
  input wire logic [3:0] cfgSlot,
  input wire logic [3:0] cfgSource,
  input wire logic       cfgReject,
  input wire logic       trigOutFromExp,
  input wire logic [2:0] trigOutExpSlot,
  input wire logic [9:0] moduleTrig,
  input wire logic [9:0] moduleArm,
  input wire logic       mainTrigOut,
  input wire logic       rearTrigOut,
  input wire logic       expPresent,
  input wire logic       linkCtrlValid,
  input wire logic       linkUp
);
  // ****
  // Properties
  // ****
  localparam int LINK_MAX = 11;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence sWrite;
    cfgWrite;
  endsequence
  sequence sAnswer;
    linkCtrlValid || cfgReject;
  endsequence
  a_bad_slot: assert property (sWrite ##0 cfgSlot > 4'h9 |=> cfgReject)
    else $error("write to missing slot not refused");
  a_self_select: assert property (sWrite ##0 cfgSource == cfgSlot |=> cfgReject)
    else $error("self arming not refused");
  a_bad_code: assert property (sWrite ##0 cfgSource inside {[4'hB:4'hE]} |=> cfgReject)
    else $error("unknown source code not refused");
  a_answer_each: assert property (sWrite |=> sAnswer)
    else $error("write left unanswered");
  a_reset_clear: assert property ($fell(sys_rst) |-> moduleArm == 10'h000 && !linkUp)
    else $error("arms or link not clear after reset");
  a_link_time: assert property ($fell(sys_rst) && expPresent |-> ##[1:LINK_MAX] linkUp)
    else $error("link not raised with frame present");
  a_rear_exp: assert property (linkUp && trigOutFromExp && trigOutExpSlot < 3'h5
    |=> rearTrigOut == $past(moduleTrig[4'h5 + trigOutExpSlot]))
    else $error("rear output does not follow expansion trigger");
  a_rear_main: assert property (!trigOutFromExp |=> rearTrigOut == $past(mainTrigOut))
    else $error("rear output does not follow main trigger");
endmodule // arm_router_monitor
bind intermodule_arming_router arm_router_monitor arm_router_monitor_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .cfgWrite(cfgWrite), .cfgSlot(cfgSlot),
  .cfgSource(cfgSource), .cfgReject(cfgReject), .trigOutFromExp(trigOutFromExp),
  .trigOutExpSlot(trigOutExpSlot), .moduleTrig(moduleTrig), .moduleArm(moduleArm),
  .mainTrigOut(mainTrigOut), .rearTrigOut(rearTrigOut), .expPresent(expPresent),
  .linkCtrlValid(linkCtrlValid), .linkUp(linkUp));
`default_nettype wire

// ==== tb/module_farm.sv ====
`timescale 1ns/100ps
`default_nettype none
module module_farm (
  // Clock
  input  wire logic       core_clk,
  // Patterns chosen by the bench
  input  wire logic [9:0] trigPat,
  input  wire logic       rearPat,
  input  wire logic       mainPat,
  // Module triggers and rear connectors
  output var logic [9:0]  moduleTrig = 10'h000,
  output var logic        rearArmIn = 1'b0,
  output var logic        mainTrigOut = 1'b0
);
  // Levels move on the falling edge, well clear of the router's sampling edge
  always @(negedge core_clk) begin
    moduleTrig <= trigPat;
    rearArmIn <= rearPat;
    mainTrigOut <= mainPat;
  end
endmodule // module_farm
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {logic acc; logic [3:0] slot; logic [3:0] src;} resp_t;
  logic core_clk = 1'b0, sys_rst = 1'b1, cfgWrite = 1'b0, trigOutFromExp = 1'b0;
  logic [3:0] cfgSlot = 4'h0, cfgSource = 4'h0, linkCtrlSlot, linkCtrlSource;
  logic [2:0] trigOutExpSlot = 3'h0;
  logic [9:0] moduleTrig, moduleArm, chainTooDeep, trigPat = 10'h000;
  logic cfgReject, rearArmIn, mainTrigOut, rearTrigOut, linkCtrlValid, linkUp;
  logic sharedPathConflict, expPresent = 1'b1, rearPat = 1'b0, mainPat = 1'b0, ph2 = 1'b0;
  logic [31:0] seed = 32'h99D8924E;
  resp_t expQ[$];
  resp_t r;
  int mismatches = 0;
  int tests_run = 0;
  always #4 core_clk = ~core_clk;
  intermodule_arming_router intermodule_arming_router_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .cfgWrite(cfgWrite), .cfgSlot(cfgSlot), .cfgSource(cfgSource),
    .cfgReject(cfgReject), .trigOutFromExp(trigOutFromExp), .trigOutExpSlot(trigOutExpSlot),
    .moduleTrig(moduleTrig), .moduleArm(moduleArm), .rearArmIn(rearArmIn),
    .mainTrigOut(mainTrigOut), .rearTrigOut(rearTrigOut), .expPresent(expPresent),
    .linkCtrlValid(linkCtrlValid), .linkCtrlSlot(linkCtrlSlot),
    .linkCtrlSource(linkCtrlSource), .linkUp(linkUp), .chainTooDeep(chainTooDeep),
    .sharedPathConflict(sharedPathConflict));
  module_farm module_farm_inst (.core_clk(core_clk), .trigPat(trigPat), .rearPat(rearPat),
    .mainPat(mainPat), .moduleTrig(moduleTrig), .rearArmIn(rearArmIn),
    .mainTrigOut(mainTrigOut));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic close_out;
    $display("counts: %0d compared, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp_val(input string n, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_resp(input resp_t e, input resp_t g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH response expected %h seen %h", e, g);
    end
  endtask
  // Back-to-back writes keep cfgWrite high; idle() lowers it
  task automatic wr(input logic [3:0] s, input logic [3:0] c, input logic a);
    cfgWrite = 1'b1;
    cfgSlot = s;
    cfgSource = c;
    expQ.push_back('{a, s, c});
    @(negedge core_clk);
  endtask
  task automatic idle(input int n);
    cfgWrite = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rand_arms(input int n);
    logic [9:0] e;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      trigPat <= seed[9:0];
      rearPat <= seed[10];
      mainPat <= seed[11];
      trigOutExpSlot = seed[14:12] % 3'h5;
      repeat (4) @(negedge core_clk);
      e = 10'h000;
      if (!ph2) begin
        e = {2'b00, rearPat, trigPat[9], 1'b0, rearPat, trigPat[5], trigPat[5], 1'b0, trigPat[1]};
      end
      cmp_val("arms", e, moduleArm);
      e[0] = (ph2 | !trigOutFromExp) ? mainPat : trigPat[4'h5 + trigOutExpSlot];
      cmp_val("rear trigger", {9'h000, e[0]}, {9'h000, rearTrigOut});
    end
  endtask
  // Pops the oldest expected answer whenever the router answers a write
  always @(negedge core_clk) begin
    if (!sys_rst && (cfgReject || linkCtrlValid)) begin
      if (expQ.size() == 0) begin
        cmp_val("spare answer", 10'h000, 10'h001);
      end else begin
        r = expQ.pop_front();
        cmp_resp(r, {linkCtrlValid, linkCtrlValid ? {linkCtrlSlot, linkCtrlSource} : {r.slot, r.src}});
      end
    end
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    cmp_val("arms at reset", 10'h000, moduleArm);
    wr(4'h2, 4'h5, 1'b0);
    idle(1);
    for (int i = 0; i < 20 && linkUp !== 1'b1; i++) @(negedge core_clk);
    cmp_val("link", 10'h001, {9'h000, linkUp});
    for (int s = 0; s < 10; s++) wr(4'(s), 4'(s), 1'b0);
    for (int c = 11; c < 15; c++) wr(4'h1, 4'(c), 1'b0);
    for (int s = 10; s < 16; s++) wr(4'(s), 4'h0, 1'b0);
    wr(4'h0, 4'h1, 1'b1);
    wr(4'h2, 4'h5, 1'b1);
    wr(4'h3, 4'h6, 1'b0);
    wr(4'h3, 4'h5, 1'b1);
    wr(4'h4, 4'hA, 1'b1);
    wr(4'h7, 4'hA, 1'b1);
    wr(4'h8, 4'h0, 1'b0);
    wr(4'h6, 4'h9, 1'b1);
    idle(3);
    cmp_val("shared path", 10'h001, {9'h000, sharedPathConflict});
    rand_arms(4);
    trigOutFromExp = 1'b1;
    rand_arms(8);
    $display("test routing done");
    sys_rst = 1'b1;
    expPresent = 1'b0;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    ph2 = 1'b1;
    wr(4'h0, 4'h5, 1'b0);
    for (int s = 5; s < 9; s++) wr(4'(s), 4'(s + 1), 1'b1);
    idle(2);
    cmp_val("four links", 10'h000, chainTooDeep);
    wr(4'h9, 4'h5, 1'b1);
    idle(2);
    cmp_val("cyclic chain", 10'h3E0, chainTooDeep);
    rand_arms(4);
    cmp_val("link absent", 10'h000, {9'h000, linkUp});
    cmp_val("answers left", 10'h000, 10'(expQ.size()));
    $display("test chains done");
    close_out();
  end
endmodule // tb
`default_nettype wire
